// *** bench/scb_checker_properties.sv ***
// Assertion checker for the sequencer counter and branch block
`timescale 1ns/1ps
module scb_checker (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire [15:0] selector_out,
    input wire [9:0] pc_out,
    input wire counter_parallel_load_n
);
    // ----------------------------------------
    // Transfer history
    // ----------------------------------------
    wire take = hsel & htrans[1] & hready & ce;
    wire rd_take = take & !hwrite;
    reg [2:0] step_hist;
    reg [3:0] act_hist;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_hist <= 3'h0;
            act_hist <= 4'h0;
        end else if (ce) begin
            step_hist <= {step_hist[1:0], rd_take & (haddr == 32'h14)};
            act_hist <= {act_hist[2:0], take};
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
    chk_pc_cause: assert property ($changed(pc_out) |-> step_hist != 3'h0)
        else $error("pc moved without a step");
    chk_pc_step_next_instr: assert property ($changed(pc_out) && counter_parallel_load_n
        && $past(counter_parallel_load_n) && $past(counter_parallel_load_n, 2)
        |-> pc_out == $past(pc_out) + 10'h001) else $error("pc did not step_next_instr by one");
    chk_ce_freeze: assert property (!ce |=> $stable(pc_out) && $stable(selector_out))
        else $error("state moved with ce low");
    chk_sel_cause: assert property ($changed(selector_out) |-> act_hist != 4'h0)
        else $error("selector moved without a transfer");
    chk_upper_zero: assert property (rd_take |=> hrdata[31:10] == 22'h0)
        else $error("read data upper bits set");
    chk_bad_addr: assert property (rd_take && (haddr[31:10] != 22'h0 || haddr[1:0] != 2'h0)
        |=> hrdata == 32'h0) else $error("bad address read not zero");
    chk_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
        else $error("read data changed without a read");
    cov_step: cover property (rd_take && haddr == 32'h14);
    cov_latch: cover property (rd_take && haddr == 32'h1C);
    cov_jump: cover property (!counter_parallel_load_n && $changed(pc_out));
endmodule // scb_checker

bind scb_top scb_checker scb_checker_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hrdata, .hreadyout, .hresp, .selector_out, .pc_out,
    .counter_parallel_load_n);

// *** bench/testbench.sv ***
// Self-checking bench for the sequencer counter and branch block
`timescale 1ns/1ps
module testbench;
    logic hclk = 0, hresetn = 0, ce = 0, hsel = 0, hwrite = 0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h87F1, rd;
    wire [31:0] hrdata;
    wire hreadyout, hresp, counter_parallel_load_n;
    wire [15:0] selector_out;
    wire [9:0] pc_out;
    wire hready = hreadyout;
    int mismatches = 0, n_tests = 0, cyc = 0;
    int lo = 0, hi = 0, pc = 0, tgt = 0, ctrl = 255, ins = 4, vl = 0, vh = 0, chain = 0;
    int tv[5] = '{16'h5555, 16'hAAAA, 16'hFFFF, 16'h0000, 16'h0000};
    int te[5] = '{16'h6000, 16'h9FFF, 16'h0001, 16'hFFFE, 16'h0000};
    int tc[5] = '{8'h5F, 8'hAF, 8'h5F, 8'hAF, 8'hFF};
    int tn[5] = '{2731, 2731, 2, 2, 3};
    scb_top scb_top_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready, .hrdata, .hreadyout, .hresp, .selector_out, .pc_out,
        .counter_parallel_load_n);
    always #5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Model and bus tasks
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        bus(1'b1, {22'h0, idx, 2'h0}, d);
    endtask
    task automatic rdi(input logic [7:0] idx);
        bus(1'b0, {22'h0, idx, 2'h0}, 32'h0);
    endtask
    task automatic setmem(input logic [7:0] sel, input int d);
        wr(8'h05, sel);
        wr(8'h06, d);
    endtask
    function automatic int nxt(int v, int m, int vec, int w);
        case (m)
            0: return vec;
            1: return (v + 1) % w;
            2: return (v + w - 1) % w;
            default: return v;
        endcase
    endfunction
    function automatic int brn();
        case (ins)
            8: return 0;
            2: return lo != 0;
            12: return hi != 0;
            10: return lo != 0 || hi != 0;
            default: return 1;
        endcase
    endfunction
    task automatic step();
        int v;
        v = nxt(hi * 256 + lo, ctrl / 64, vh * 256 + vl, 65536);
        rdi(8'h05);
        pc = brn() ? (pc + 1) % 1024 : tgt;
        if (chain) begin
            hi = v / 256;
            lo = v % 256;
        end else begin
            lo = nxt(lo, ctrl / 64, vl, 256);
            hi = nxt(hi, ctrl / 16 % 4, vh, 256);
        end
        repeat (2) @(posedge hclk);
        #1;
        v = chain ? hi * 256 + lo : lo;
        check("selector", chain ? selector_out : selector_out[7:0], v);
    endtask
    task automatic load(input int vword, input int code);
        vl = vword % 256;
        vh = vword / 256;
        setmem(8'h7E, vl);
        setmem(8'h7D, vh);
        ctrl = 8'h0F;
        setmem(8'h5F, ctrl);
        step();
        ctrl = code;
        setmem(8'h5F, ctrl);
    endtask
    task automatic latch(input int exp);
        rdi(8'h07);
        rdi(8'h10);
        check("readback low", rd, exp % 256);
        rdi(8'h11);
        if (chain) check("readback high", rd, exp / 256);
    endtask
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        ce <= 1'b1;
        #1;
        check("load_n", counter_parallel_load_n, 1);
        check("selector", selector_out, 0);
        rdi(8'h04);
        check("status off", rd, 0);
        bus(1'b1, 32'h448, 32'h40);
        bus(1'b0, 32'h400, 32'h0);
        check("unmapped", rd, 0);
        bus(1'b0, 32'h4A, 32'h0);
        check("misaligned", rd, 0);
        rdi(8'h12);
        check("config", rd, 0);
        $display("reset and address test done");
        wr(8'h0C, 8'h20);
        for (int m = 0; m < 4; m++) begin
            load(16'h00FF, m * 80 + 15);
            repeat (2) step();
            latch(lo);
            wr(8'h0C, 8'h10);
            latch(hi);
            wr(8'h0C, 8'h20);
        end
        $display("8-bit mode test done");
        wr(8'h12, 8'h40);
        chain = 1;
        tv[4] = rnd() % 65536;
        te[4] = tv[4];
        for (int i = 0; i < 5; i++) begin
            load(tv[i], tc[i]);
            repeat (tn[i]) step();
            latch(hi * 256 + lo);
            check("final count", selector_out, te[i]);
        end
        rdi(8'h14);
        check("pc", rd, pc);
        $display("16-bit mode test done");
        wr(8'h04, 8'h80);
        for (int k = 0; k < 3; k++) begin
            load((k == 1 ? 16'h5A00 : 0) + (k == 2 ? 16'h00A5 : 0), 8'hFF);
            for (int c = 0; c < 16; c++) begin
                ins = c;
                setmem(8'h6F, c * 16 + rnd() % 16);
                tgt = rnd() % 1024;
                wr(8'h13, tgt);
                rdi(8'h04);
                check("status", rd, brn() ? 0 : 4);
                check("load_n", counter_parallel_load_n, brn());
                step();
                rdi(8'h14);
                check("pc", rd, pc);
                check("pc pin", pc_out, pc);
            end
        end
        ce <= 1'b0;
        rdi(8'h05);
        ce <= 1'b1;
        rdi(8'h14);
        check("pc frozen", rd, pc);
        $display("branch and freeze test done");
        stop_test();
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
endmodule // testbench

// *** design/scb_counter.v ***
// Two 8-bit counting registers that chain into one 16-bit counter
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_counter (
    hclk,
    hresetn,
    ce,
    step,
    chain,
    mode_low,
    mode_high,
    vector_low_byte,
    vector_high_byte,
    count_reg_low,
    count_reg_high
);
    input wire hclk;
    input wire hresetn;
    input wire ce;
    input wire step;
    input wire chain;
    input wire [1:0] mode_low;
    input wire [1:0] mode_high;
    input wire [7:0] vector_low_byte;
    input wire [7:0] vector_high_byte;
    output reg [7:0] count_reg_low;
    output reg [7:0] count_reg_high;

    reg [15:0] wide_next;
    reg [7:0] low_next;
    reg [7:0] high_next;

    // ------------------------------------------------------------
    // Mode step
    // ------------------------------------------------------------
    function [7:0] step8;
        input [7:0] value;
        input [7:0] vec;
        input [1:0] mode;
        begin
            case (mode)
                `SCB_MODE_LOAD: step8 = vec;
                `SCB_MODE_INC: step8 = value + 8'h01;
                `SCB_MODE_DEC: step8 = value - 8'h01;
                default: step8 = value;
            endcase
        end
    endfunction

    always @* begin
        wide_next = {count_reg_high, count_reg_low};
        case (mode_low)
            `SCB_MODE_LOAD: wide_next = {vector_high_byte, vector_low_byte};
            `SCB_MODE_INC: wide_next = {count_reg_high, count_reg_low} + 16'h0001;
            `SCB_MODE_DEC: wide_next = {count_reg_high, count_reg_low} - 16'h0001;
            default: wide_next = {count_reg_high, count_reg_low};
        endcase
        if (chain) begin
            low_next = wide_next[7:0];
            high_next = wide_next[15:8];
        end else begin
            low_next = step8(count_reg_low, vector_low_byte, mode_low);
            high_next = step8(count_reg_high, vector_high_byte, mode_high);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg_low <= `SCB_RST_BYTE;
            count_reg_high <= `SCB_RST_BYTE;
        end else if (ce && step) begin
            count_reg_low <= low_next;
            count_reg_high <= high_next;
        end
    end
endmodule // scb_counter

// *** design/scb_defines.vh ***
// Constants of the sequencer counter and branch control block
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH
// Port indices; byte address is four times the index
`define SCB_IDX_STATUS 8'h04
`define SCB_IDX_SELECT 8'h05
`define SCB_IDX_DATA 8'h06
`define SCB_IDX_LATCH 8'h07
`define SCB_IDX_OUTSEL 8'h0C
`define SCB_IDX_RB_LOW 8'h10
`define SCB_IDX_RB_HIGH 8'h11
`define SCB_IDX_CONFIG 8'h12
`define SCB_IDX_TARGET 8'h13
`define SCB_IDX_PC 8'h14
// Field positions
`define SCB_CFG_CHAIN_BIT 6
`define SCB_SEL_VEC_LOW_BIT 0
`define SCB_SEL_VEC_HIGH_BIT 1
`define SCB_SEL_INSTR_BIT 4
`define SCB_SEL_CTRL_BIT 5
`define SCB_STATUS_BIT 2
// Codes
`define SCB_STATUS_ENABLE 8'h80
`define SCB_OUTSEL_LOW 8'h20
`define SCB_OUTSEL_HIGH 8'h10
`define SCB_MODE_LOAD 2'h0
`define SCB_MODE_INC 2'h1
`define SCB_MODE_DEC 2'h2
`define SCB_MODE_HOLD 2'h3
`define SCB_BR_STEP_NEXT_INSTR 4'h4
`define SCB_BR_JUMP 4'h8
`define SCB_BR_LOW_ZERO 4'h2
`define SCB_BR_HIGH_ZERO 4'hC
`define SCB_BR_BOTH_ZERO 4'hA
// Reset values
`define SCB_RST_SELECT 8'hFF
`define SCB_RST_CTRL 8'hFF
`define SCB_RST_INSTR 8'h40
`define SCB_RST_BYTE 8'h00
`define SCB_RST_PC 10'h000
`endif

// *** design/scb_top.v ***
// Sequencer counter and branch control with an AHB-Lite register slave
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_top (
    hclk,
    hresetn,
    ce,
    hsel,
    haddr,
    htrans,
    hwrite,
    hsize,
    hwdata,
    hready,
    hrdata,
    hreadyout,
    hresp,
    selector_out,
    pc_out,
    counter_parallel_load_n
);
    input wire hclk;
    input wire hresetn;
    input wire ce;
    input wire hsel;
    input wire [31:0] haddr;
    input wire [1:0] htrans;
    input wire hwrite;
    input wire [2:0] hsize;
    input wire [31:0] hwdata;
    input wire hready;
    output reg [31:0] hrdata;
    output reg hreadyout;
    output reg hresp;
    output reg [15:0] selector_out;
    output reg [9:0] pc_out;
    output reg counter_parallel_load_n;

    reg wr_pend_reg;
    reg [7:0] wr_idx_reg;
    reg [7:0] select_reg;
    reg [7:0] ctrl_word_reg;
    reg [7:0] instr_word_reg;
    reg [7:0] vector_low_byte;
    reg [7:0] vector_high_byte;
    reg [7:0] outsel_reg;
    reg [7:0] status_sel_reg;
    reg [7:0] config_reg;
    reg [9:0] target_reg;
    reg [7:0] latch_low_reg;
    reg [7:0] latch_high_reg;
    reg step_reg;
    reg [31:0] rdata_next;
    reg branch_out;
    reg [15:0] sel_next;
    wire [7:0] count_reg_low;
    wire [7:0] count_reg_high;
    wire [3:0] branch_select_field;
    wire [1:0] counter_mode_low;
    wire [1:0] counter_mode_high;
    wire chain;
    wire acc;
    wire [7:0] acc_idx;
    wire mapped;
    wire rd_acc;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function is_mapped;
        input [31:0] addr;
        begin
            is_mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'h0);
        end
    endfunction

    assign acc = hsel && htrans[1] && hready;
    assign acc_idx = haddr[9:2];
    assign mapped = is_mapped(haddr);
    assign rd_acc = acc && !hwrite && mapped;

    // Control word: bits 7:6 low register, bits 5:4 high register
    assign counter_mode_low = ctrl_word_reg[7:6];
    assign counter_mode_high = ctrl_word_reg[5:4];
    assign chain = config_reg[`SCB_CFG_CHAIN_BIT];
    assign branch_select_field = instr_word_reg[7:4];

    // ------------------------------------------------------------
    // Counting registers
    // ------------------------------------------------------------
    scb_counter u_counter (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .step(step_reg),
        .chain(chain),
        .mode_low(counter_mode_low),
        .mode_high(counter_mode_high),
        .vector_low_byte(vector_low_byte),
        .vector_high_byte(vector_high_byte),
        .count_reg_low(count_reg_low),
        .count_reg_high(count_reg_high)
    );

    // ------------------------------------------------------------
    // Branch condition multiplexer
    // ------------------------------------------------------------
    always @* begin
        case (branch_select_field)
            `SCB_BR_STEP_NEXT_INSTR: branch_out = 1'b1;
            `SCB_BR_JUMP: branch_out = 1'b0;
            `SCB_BR_LOW_ZERO: branch_out = (count_reg_low != 8'h00);
            `SCB_BR_HIGH_ZERO: branch_out = (count_reg_high != 8'h00);
            `SCB_BR_BOTH_ZERO: branch_out = ({count_reg_high, count_reg_low} != 16'h0000);
            default: branch_out = 1'b1;
        endcase
    end

    // ------------------------------------------------------------
    // Output selector
    // ------------------------------------------------------------
    always @* begin
        case (outsel_reg)
            `SCB_OUTSEL_LOW: begin
                if (chain) begin
                    sel_next = {count_reg_high, count_reg_low};
                end else begin
                    sel_next = {8'h00, count_reg_low};
                end
            end
            `SCB_OUTSEL_HIGH: sel_next = {8'h00, count_reg_high};
            default: sel_next = {vector_high_byte, vector_low_byte};
        endcase
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (acc_idx)
            `SCB_IDX_STATUS: begin
                if (status_sel_reg == `SCB_STATUS_ENABLE) begin
                    rdata_next[`SCB_STATUS_BIT] = ~branch_out;
                end
            end
            `SCB_IDX_SELECT: rdata_next = {24'h000000, select_reg};
            `SCB_IDX_DATA: rdata_next = {24'h000000, ctrl_word_reg};
            `SCB_IDX_OUTSEL: rdata_next = {24'h000000, outsel_reg};
            `SCB_IDX_RB_LOW: rdata_next = {24'h000000, latch_low_reg};
            `SCB_IDX_RB_HIGH: rdata_next = {24'h000000, latch_high_reg};
            `SCB_IDX_CONFIG: rdata_next = {24'h000000, config_reg};
            `SCB_IDX_TARGET: rdata_next = {22'h000000, target_reg};
            `SCB_IDX_PC: rdata_next = {22'h000000, pc_out};
            default: rdata_next = 32'h00000000;
        endcase
        if (!mapped) begin
            rdata_next = 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Bus phases and read side effects
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            step_reg <= 1'b0;
            latch_low_reg <= `SCB_RST_BYTE;
            latch_high_reg <= `SCB_RST_BYTE;
        end else if (ce) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= acc && hwrite && mapped;
            wr_idx_reg <= acc_idx;
            step_reg <= rd_acc && (acc_idx == `SCB_IDX_SELECT);
            if (acc && !hwrite) begin
                hrdata <= rdata_next;
            end
            if (rd_acc && (acc_idx == `SCB_IDX_LATCH)) begin
                latch_low_reg <= selector_out[7:0];
                latch_high_reg <= selector_out[15:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            select_reg <= `SCB_RST_SELECT;
            ctrl_word_reg <= `SCB_RST_CTRL;
            instr_word_reg <= `SCB_RST_INSTR;
            vector_low_byte <= `SCB_RST_BYTE;
            vector_high_byte <= `SCB_RST_BYTE;
            outsel_reg <= `SCB_RST_BYTE;
            status_sel_reg <= `SCB_RST_BYTE;
            config_reg <= `SCB_RST_BYTE;
            target_reg <= 10'h000;
        end else if (ce && wr_pend_reg) begin
            case (wr_idx_reg)
                `SCB_IDX_STATUS: status_sel_reg <= hwdata[7:0];
                `SCB_IDX_SELECT: select_reg <= hwdata[7:0];
                `SCB_IDX_DATA: begin
                    if (!select_reg[`SCB_SEL_CTRL_BIT]) begin
                        ctrl_word_reg <= hwdata[7:0];
                    end
                    if (!select_reg[`SCB_SEL_INSTR_BIT]) begin
                        instr_word_reg <= hwdata[7:0];
                    end
                    if (!select_reg[`SCB_SEL_VEC_LOW_BIT]) begin
                        vector_low_byte <= hwdata[7:0];
                    end
                    if (!select_reg[`SCB_SEL_VEC_HIGH_BIT]) begin
                        vector_high_byte <= hwdata[7:0];
                    end
                end
                `SCB_IDX_OUTSEL: outsel_reg <= hwdata[7:0];
                `SCB_IDX_CONFIG: config_reg <= hwdata[7:0];
                `SCB_IDX_TARGET: target_reg <= hwdata[9:0];
                default: target_reg <= target_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Program counter and registered outputs
    // ------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_out <= `SCB_RST_PC;
            counter_parallel_load_n <= 1'b1;
            selector_out <= 16'h0000;
        end else if (ce) begin
            counter_parallel_load_n <= branch_out;
            selector_out <= sel_next;
            if (step_reg) begin
                if (!branch_out) begin
                    pc_out <= target_reg;
                end else begin
                    pc_out <= pc_out + 10'h001;
                end
            end
        end
    end
endmodule // scb_top
